/* File: hw/ipr_regs.svh */
// Offsets, field layout, reset values and source map of the priority bank
`ifndef IPR_REGS_SVH
`define IPR_REGS_SVH

// ----------------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------------
`define IPR_ADDR_W 4
`define IPR_DATA_W 16
`define IPR_NREG   6
`define IPR_IDX_W  3
`define IPR_NSRC   20
`define IPR_LVL_W  3

// ----------------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define IPR_OFF_PRIORITY_CTRL_5  4'h0
`define IPR_OFF_PRIORITY_CTRL_6  4'h1
`define IPR_OFF_PRIORITY_CTRL_7  4'h2
`define IPR_OFF_PRIORITY_CTRL_8  4'h3
`define IPR_OFF_PRIORITY_CTRL_9  4'h4
`define IPR_OFF_PRIORITY_CTRL_10 4'h5

// ----------------------------------------------------------------------------
// Implemented-bit masks and reset values (every field resets to level 4)
// ----------------------------------------------------------------------------
`define IPR_MASK_FULL 16'h7777
`define IPR_MASK_5    16'h0707
`define IPR_MASK_8    16'h0077
`define IPR_RST_FULL  16'h4444
`define IPR_RST_5     16'h0404
`define IPR_RST_8     16'h0044
`define IPR_LEVEL_RST 60'h924924924924924
`define IPR_LEVEL_OFF 3'h0
`define IPR_LEVEL_TOP 3'h7
`define IPR_LEVEL_LOW 3'h1

// ----------------------------------------------------------------------------
// Field positions inside their registers
// ----------------------------------------------------------------------------
`define IPR_F3_LSB 12
`define IPR_F2_LSB 8
`define IPR_F1_LSB 4
`define IPR_F0_LSB 0

// ----------------------------------------------------------------------------
// Source indices on the level and request vectors
// ----------------------------------------------------------------------------
`define IPR_SRC_CAPTURE7_LEVEL      0
`define IPR_SRC_EXT_IRQ1_LEVEL      1
`define IPR_SRC_TIMER4_LEVEL        2
`define IPR_SRC_COMPARE4_LEVEL      3
`define IPR_SRC_COMPARE3_LEVEL      4
`define IPR_SRC_DMA_CH2_LEVEL       5
`define IPR_SRC_UART2_TX_LEVEL      6
`define IPR_SRC_UART2_RX_LEVEL      7
`define IPR_SRC_EXT_IRQ2_LEVEL      8
`define IPR_SRC_TIMER5_LEVEL        9
`define IPR_SRC_SERIAL2_EVENT_LEVEL 10
`define IPR_SRC_SERIAL2_FAULT_LEVEL 11
`define IPR_SRC_CAPTURE5_LEVEL      12
`define IPR_SRC_CAPTURE4_LEVEL      13
`define IPR_SRC_CAPTURE3_LEVEL      14
`define IPR_SRC_DMA_CH3_LEVEL       15
`define IPR_SRC_COMPARE7_LEVEL      16
`define IPR_SRC_COMPARE6_LEVEL      17
`define IPR_SRC_COMPARE5_LEVEL      18
`define IPR_SRC_CAPTURE6_LEVEL      19

// Register index per source, source 19 first, 3 bits each
`define IPR_SRC_REG_TAB {3'h5, 3'h5, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4, 3'h3, 3'h3, \
                         3'h2, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h0}
// Field low bit per source, source 19 first, 4 bits each
`define IPR_SRC_LSB_TAB {4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4, \
                         4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h4, 4'h8, 4'hC, 4'h0, 4'h8}

`endif

/* File: hw/ipr_pkg.sv */
// Types shared by the priority bank modules
package ipr_pkg;

    // ------------------------------------------------------------------------
    // Port and storage types
    // ------------------------------------------------------------------------
    typedef logic [3:0]       ipr_addr_t;    // Register port address
    typedef logic [15:0]      ipr_data_t;    // Register data word
    typedef logic [2:0]       ipr_idx_t;     // Decoded register index
    typedef logic [5:0][15:0] ipr_bank_t;    // The six priority words
    typedef logic [59:0]      ipr_lvl_vec_t; // Twenty 3-bit levels
    typedef logic [19:0]      ipr_req_t;     // One request bit per source

    // ------------------------------------------------------------------------
    // Complete state of the top module
    // ------------------------------------------------------------------------
    typedef struct packed {
        ipr_bank_t    regs_r;  // Stored priority words
        ipr_data_t    rdata_r; // Read data, valid the cycle after a read
        ipr_lvl_vec_t level_r; // Levels presented to the resolver
        ipr_req_t     req_r;   // Gated requests presented to the resolver
    } ipr_state_t;

endpackage

/* File: hw/ipr_if.sv */
// Carrier between the bank top, its decoder and its level gate
`timescale 1ns/1ps
interface ipr_if;
    import ipr_pkg::*;

    ipr_addr_t    addr;       // Register address
    logic         wr;         // Write strobe
    logic         rd;         // Read strobe
    ipr_idx_t     idx;        // Decoded word index
    logic         hit;        // Address names a register
    logic         wr_en;      // Write to a mapped register
    logic         rd_en;      // Read of a mapped register
    ipr_bank_t    regs;       // Stored words
    ipr_req_t     periph_req; // Raw requests from the sources
    ipr_lvl_vec_t levels;     // Extracted levels
    ipr_req_t     gated;      // Requests of enabled sources

    // Decoder end
    modport dec_mp (
        input  addr,
        input  wr,
        input  rd,
        output idx,
        output hit,
        output wr_en,
        output rd_en
    );

    // Level gate end
    modport gate_mp (
        input  regs,
        input  periph_req,
        output levels,
        output gated
    );
endinterface

/* File: hw/ipr_decode.sv */
// Address decoder of the priority bank
`timescale 1ns/1ps
`include "ipr_regs.svh"
module ipr_decode (
    ipr_if.dec_mp bus
);
    import ipr_pkg::*;

    // ------------------------------------------------------------------------
    // Map the address to a word index; anything else is a miss
    // ------------------------------------------------------------------------
    always_comb begin
        bus.hit = 1'b1;
        bus.idx = 3'h0;
        unique case (bus.addr)
            `IPR_OFF_PRIORITY_CTRL_5:  bus.idx = 3'h0;
            `IPR_OFF_PRIORITY_CTRL_6:  bus.idx = 3'h1;
            `IPR_OFF_PRIORITY_CTRL_7:  bus.idx = 3'h2;
            `IPR_OFF_PRIORITY_CTRL_8:  bus.idx = 3'h3;
            `IPR_OFF_PRIORITY_CTRL_9:  bus.idx = 3'h4;
            `IPR_OFF_PRIORITY_CTRL_10: bus.idx = 3'h5;
            default:                   bus.hit = 1'b0;
        endcase
        // Unmapped writes change nothing, unmapped reads return zero
        bus.wr_en = bus.wr & bus.hit;
        bus.rd_en = bus.rd & bus.hit;
    end
endmodule

/* File: hw/ipr_gate.sv */
// Per-source level extraction and request gating
`timescale 1ns/1ps
`include "ipr_regs.svh"
module ipr_gate (
    ipr_if.gate_mp bus
);
    import ipr_pkg::*;

    localparam logic [59:0] REG_TAB = `IPR_SRC_REG_TAB; // Word of each source
    localparam logic [79:0] LSB_TAB = `IPR_SRC_LSB_TAB; // Field low bit of each source

    // ------------------------------------------------------------------------
    // One slice per source: pick its field, block it when the level is zero
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < `IPR_NSRC; i++) begin : g_src
        localparam logic [2:0] RI = REG_TAB[3*i +: 3];
        localparam logic [3:0] LB = LSB_TAB[4*i +: 4];
        assign bus.levels[3*i +: 3] = bus.regs[RI][LB +: 3];
        assign bus.gated[i] = bus.periph_req[i] & (bus.regs[RI][LB +: 3] != `IPR_LEVEL_OFF); // R3
    end
endmodule

/* File: hw/ipr_bank.sv */
// Interrupt priority register bank, words 5 to 10, with level outputs
//
// Notes on behaviour
// (R1) Code seven means level seven, the highest
// (R2) Code one is lowest level; others map numerically
// (R3) Code zero disables; its request never passes
// (R4) Unimplemented bits always read as zero
// (R5) Every field resets to level four
// (R6) Fields read back exactly what was written
// (R7) Word 5: capture7 at 10-8, irq1 at 2-0
// (R8) Word 6: timer4, compare4, compare3, dma2
// (R9) Word 7: uart2 tx, uart2 rx, irq2, timer5
// (R10) Word 8: serial2 event 6-4, fault 2-0
// (R11) Word 9: capture5, capture4, capture3, dma3
// (R12) Word 10: compare7, compare6, compare5, capture6
// (R13) Unused bits ignore writes; levels always presented
`timescale 1ns/1ps
`include "ipr_regs.svh"
module ipr_bank (
    input  wire logic                 clk_sys,
    input  wire logic                 rst,
    input  wire ipr_pkg::ipr_addr_t   reg_addr,
    input  wire ipr_pkg::ipr_data_t   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output      ipr_pkg::ipr_data_t   reg_rdata,
    input  wire ipr_pkg::ipr_req_t    periph_req,
    output      ipr_pkg::ipr_lvl_vec_t src_level,
    output      ipr_pkg::ipr_req_t    core_req
);
    import ipr_pkg::*;

    // ------------------------------------------------------------------------
    // State and reset image
    // ------------------------------------------------------------------------
    localparam ipr_state_t ST_RST = '{
        regs_r:  {`IPR_RST_FULL, `IPR_RST_FULL, `IPR_RST_8,
                  `IPR_RST_FULL, `IPR_RST_FULL, `IPR_RST_5},
        rdata_r: 16'h0000,
        level_r: `IPR_LEVEL_RST,
        req_r:   20'h00000
    };

    ipr_state_t s_r;   // Registered state
    ipr_state_t s_nxt; // Next state
    ipr_if      bus(); // Carrier to decoder and gate

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    assign bus.addr       = reg_addr;
    assign bus.wr         = reg_wr;
    assign bus.rd         = reg_rd;
    assign bus.regs       = s_r.regs_r;
    assign bus.periph_req = periph_req;

    // Address decoder
    ipr_decode u_decode (
        .bus (bus)
    );

    // Level extraction and request gating
    ipr_gate u_gate (
        .bus (bus)
    );

    // ------------------------------------------------------------------------
    // Implemented-bit mask of a word
    // ------------------------------------------------------------------------
    function automatic ipr_data_t impl_mask(input ipr_idx_t idx);
        ipr_data_t m;
        m = `IPR_MASK_FULL;
        if (idx == 3'h0) begin
            m = `IPR_MASK_5;
        end else if (idx == 3'h3) begin
            m = `IPR_MASK_8;
        end
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        // Read data stand only in the cycle after the read
        s_nxt.rdata_r = 16'h0000;
        if (bus.rd_en) begin
            s_nxt.rdata_r = s_r.regs_r[bus.idx]; // R4 R6
        end
        // Store only implemented bits so the rest stays zero
        if (bus.wr_en) begin
            s_nxt.regs_r[bus.idx] = reg_wdata & impl_mask(bus.idx); // R6 R13
        end
        // Levels and gated requests follow the stored words every cycle
        s_nxt.level_r = bus.levels; // R1 R2 R7 R8 R9 R10 R11 R12 R13
        s_nxt.req_r   = bus.gated;  // R3
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_r <= ST_RST; // R5
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, straight from the state register
    // ------------------------------------------------------------------------
    assign reg_rdata = s_r.rdata_r;
    assign src_level = s_r.level_r;
    assign core_req  = s_r.req_r;

    // ------------------------------------------------------------------------
    // Helpers read only by the checks below
    // ------------------------------------------------------------------------
    ipr_req_t lvl_nonzero; // Level of each source is not zero
    for (genvar i = 0; i < `IPR_NSRC; i++) begin : g_chk
        assign lvl_nonzero[i] = (s_r.level_r[3*i +: 3] != `IPR_LEVEL_OFF);
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // All-ones code in capture7 field reaches the resolver as seven
    a_top_level_seven: assert property (@(posedge clk_sys) disable iff (rst) // R1
        (reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_5 && reg_wdata[10:8] == `IPR_LEVEL_TOP)
        ##1 !(reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_5)
        |=> src_level[3*`IPR_SRC_CAPTURE7_LEVEL +: 3] == `IPR_LEVEL_TOP)
        else $error("capture7 level not seven after write");

    // Code one in ext_irq1 field reaches the resolver as one
    a_low_level_one: assert property (@(posedge clk_sys) disable iff (rst) // R2
        (reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_5 && reg_wdata[2:0] == `IPR_LEVEL_LOW)
        ##1 !(reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_5)
        |=> src_level[3*`IPR_SRC_EXT_IRQ1_LEVEL +: 3] == `IPR_LEVEL_LOW)
        else $error("ext_irq1 level not one after write");

    // No request leaves for a source whose level is zero
    a_zero_blocks_req: assert property (@(posedge clk_sys) disable iff (rst) // R3
        (core_req & ~lvl_nonzero) == 20'h00000)
        else $error("request passed for disabled source");

    // Enabled timer4 source with a request passes it on the next cycle
    a_req_passes: assert property (@(posedge clk_sys) disable iff (rst) // R3
        (periph_req[`IPR_SRC_TIMER4_LEVEL] && s_r.regs_r[1][14:12] != `IPR_LEVEL_OFF)
        |=> core_req[`IPR_SRC_TIMER4_LEVEL])
        else $error("enabled timer4 request lost");

    // Word 8 reads zero in its upper nine bits
    a_unimpl_read_zero: assert property (@(posedge clk_sys) disable iff (rst) // R4 R10
        (reg_rd && reg_addr == `IPR_OFF_PRIORITY_CTRL_8) |=> reg_rdata[15:7] == 9'h000)
        else $error("unimplemented bits of word 8 read nonzero");

    // After reset words 5, 6 and 8 and every source level hold level four
    a_reset_level_four: assert property (@(posedge clk_sys) disable iff (rst) // R5
        $past(rst) |-> (s_r.regs_r[0] == `IPR_RST_5 && s_r.regs_r[3] == `IPR_RST_8
                        && s_r.regs_r[1] == `IPR_RST_FULL && src_level == `IPR_LEVEL_RST))
        else $error("bank not at level four after reset");

    // Write then read of word 6 returns the written fields
    a_write_read_back: assert property (@(posedge clk_sys) disable iff (rst) // R6
        (reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_6)
        ##1 (reg_rd && reg_addr == `IPR_OFF_PRIORITY_CTRL_6)
        |=> reg_rdata == ($past(reg_wdata, 2) & `IPR_MASK_FULL))
        else $error("word 6 read back differs from write");

    // Read data stand one cycle only
    a_rdata_one_cycle: assert property (@(posedge clk_sys) disable iff (rst) // R6
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read answer cycle");

    // Word 5 keeps only its two fields
    a_word5_layout: assert property (@(posedge clk_sys) disable iff (rst) // R7 R13
        (reg_wr && reg_addr == `IPR_OFF_PRIORITY_CTRL_5 && reg_wdata == 16'hFFFF)
        |=> s_r.regs_r[0] == `IPR_MASK_5 ##1 src_level[3*`IPR_SRC_CAPTURE7_LEVEL +: 3] ==
            $past(s_r.regs_r[0][10:8]))
        else $error("word 5 layout wrong");

    // Timer4 level comes from word 6 bits 14-12
    a_word6_timer4: assert property (@(posedge clk_sys) disable iff (rst) // R8
        1'b1 |=> src_level[3*`IPR_SRC_TIMER4_LEVEL +: 3] == $past(s_r.regs_r[1][14:12]))
        else $error("timer4 level not from word 6");

    // Uart2 tx level comes from word 7 bits 14-12
    a_word7_uart2tx: assert property (@(posedge clk_sys) disable iff (rst) // R9
        1'b1 |=> src_level[3*`IPR_SRC_UART2_TX_LEVEL +: 3] == $past(s_r.regs_r[2][14:12]))
        else $error("uart2 tx level not from word 7");

    // Serial2 event level comes from word 8 bits 6-4
    a_word8_event: assert property (@(posedge clk_sys) disable iff (rst) // R10
        1'b1 |=> src_level[3*`IPR_SRC_SERIAL2_EVENT_LEVEL +: 3] == $past(s_r.regs_r[3][6:4]))
        else $error("serial2 event level not from word 8");

    // Dma channel 3 level comes from word 9 bits 2-0
    a_word9_dma3: assert property (@(posedge clk_sys) disable iff (rst) // R11
        1'b1 |=> src_level[3*`IPR_SRC_DMA_CH3_LEVEL +: 3] == $past(s_r.regs_r[4][2:0]))
        else $error("dma3 level not from word 9");

    // Compare7 level comes from word 10 bits 14-12
    a_word10_compare7: assert property (@(posedge clk_sys) disable iff (rst) // R12
        1'b1 |=> src_level[3*`IPR_SRC_COMPARE7_LEVEL +: 3] == $past(s_r.regs_r[5][14:12]))
        else $error("compare7 level not from word 10");

    // Unmapped writes leave the bank untouched
    a_unmapped_write: assert property (@(posedge clk_sys) disable iff (rst) // R13
        (reg_wr && reg_addr > `IPR_OFF_PRIORITY_CTRL_10) |=> $stable(s_r.regs_r))
        else $error("unmapped write changed the bank");

endmodule

/* File: tb/ipr_resolver_model.sv */
// Behavioural model of the core resolver that consumes the bank's levels
`timescale 1ns/1ps
module ipr_resolver_model (
    input  wire ipr_pkg::ipr_lvl_vec_t src_level,
    input  wire ipr_pkg::ipr_req_t     core_req,
    output logic [2:0]                 win_level
);
    import ipr_pkg::*;

    // ------------------------------------------------------------------------
    // Resolution
    // ------------------------------------------------------------------------
    // Highest level among the requests that actually reach the core
    always_comb begin
        win_level = 3'h0;
        for (int i = 0; i < 20; i++) begin
            // A disabled source never shows a request, so it never wins
            if (core_req[i] && (src_level[3*i +: 3] > win_level)) begin
                win_level = src_level[3*i +: 3];
            end
        end
    end
endmodule

/* File: tb/ipr_bank_tb.sv */
// Self-checking bench for the priority bank with its resolver partner
`timescale 1ns/1ps
module ipr_bank_tb;
    import ipr_pkg::*;

    // ------------------------------------------------------------------------
    // Signals and bookkeeping
    // ------------------------------------------------------------------------
    typedef struct { ipr_addr_t a; ipr_data_t w; ipr_data_t e; } ipr_row_t;

    localparam ipr_bank_t RST_WORDS = {16'h4444, 16'h4444, 16'h0044, 16'h4444, 16'h4444, 16'h0404};

    logic         clk_sys;         // System clock
    logic         rst;             // Synchronous reset
    ipr_addr_t    reg_addr;        // Register address
    ipr_data_t    reg_wdata;       // Write data
    logic         reg_wr;          // Write strobe
    logic         reg_rd;          // Read strobe
    ipr_data_t    reg_rdata;       // Read data
    ipr_req_t     periph_req;      // Raw requests
    ipr_lvl_vec_t src_level;       // Levels out
    ipr_req_t     core_req;        // Gated requests
    logic [2:0]   win_level;       // Resolver winner
    ipr_bank_t    shadow;          // Expected stored words
    ipr_data_t    rd_val;          // Last value read
    int           miscompares = 0; // Mismatch count
    int           checked = 0;     // Comparison count
    int           cycles = 0;      // Timeout counter

    // Address, write data, expected read back
    ipr_row_t rows [10] = '{
        '{4'h0, 16'hFFFF, 16'h0707}, '{4'h1, 16'hFFFF, 16'h7777},
        '{4'h2, 16'h9ABC, 16'h1234}, '{4'h3, 16'hFFFF, 16'h0077},
        '{4'h4, 16'h8888, 16'h0000}, '{4'h5, 16'hDEF0, 16'h5670},
        '{4'h0, 16'h0101, 16'h0101}, '{4'h3, 16'h0035, 16'h0035},
        '{4'h6, 16'hFFFF, 16'h0000}, '{4'hF, 16'hFFFF, 16'h0000}
    };

    // ------------------------------------------------------------------------
    // Design and partner
    // ------------------------------------------------------------------------
    ipr_bank ipr_bank_i (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_wr     (reg_wr),
        .reg_rd     (reg_rd),
        .reg_rdata  (reg_rdata),
        .periph_req (periph_req),
        .src_level  (src_level),
        .core_req   (core_req)
    );

    ipr_resolver_model ipr_resolver_model_i (
        .src_level (src_level),
        .core_req  (core_req),
        .win_level (win_level)
    );

    // ------------------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------------------
    // Levels laid out by source index from the expected words
    function automatic ipr_lvl_vec_t lv_of(input ipr_bank_t w);
        ipr_lvl_vec_t v;
        v = '0;
        v[2:0] = w[0][10:8];
        v[5:3] = w[0][2:0];
        v[32:30] = w[3][6:4];
        v[35:33] = w[3][2:0];
        for (int k = 0; k < 4; k++) begin
            v[3*(2+k) +: 3] = w[1][12-4*k +: 3];
            v[3*(6+k) +: 3] = w[2][12-4*k +: 3];
            v[3*(12+k) +: 3] = w[4][12-4*k +: 3];
            v[3*(16+k) +: 3] = w[5][12-4*k +: 3];
        end
        return v;
    endfunction

    // Requests of enabled sources, and the highest requesting level
    function automatic logic [59:0] req_of(input ipr_lvl_vec_t v, input ipr_req_t p, input logic top);
        logic [59:0] r;
        r = '0;
        for (int i = 0; i < 20; i++) begin
            if (!top) begin
                r[i] = p[i] && (v[3*i +: 3] != 3'h0);
            end else if (p[i] && (v[3*i +: 3] > r[2:0])) begin
                r[2:0] = v[3*i +: 3];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------------------
    // Compare, bus and closing tasks
    // ------------------------------------------------------------------------
    task automatic cmp_word(input string name, input ipr_data_t exp, input ipr_data_t got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmp_vec(input string name, input logic [59:0] exp, input logic [59:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input ipr_addr_t a, input ipr_data_t d);
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask

    // Read data is looked at in the one cycle that it stands
    task automatic rd_reg(input ipr_addr_t a);
        @(posedge clk_sys);
        reg_rd   <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        rd_val = reg_rdata;
    endtask

    task automatic check_outs();
        ipr_lvl_vec_t v;
        v = lv_of(shadow);
        cmp_vec("src_level", v, src_level);
        cmp_vec("core_req", req_of(v, periph_req, 1'h0), {40'h0, core_req});
        cmp_vec("win_level", req_of(v, periph_req, 1'h1), {57'h0, win_level});
    endtask

    // Write, read back, then check the outputs toward the core
    task automatic row_step(input ipr_addr_t a, input ipr_data_t w, input ipr_data_t e);
        wr_reg(a, w);
        rd_reg(a);
        cmp_word("reg_rdata", e, rd_val);
        if (a < 4'h6) begin
            shadow[a] = e;
        end
        check_outs();
    endtask

    task automatic tally_and_finish();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------------------
    // 250 MHz system clock
    initial begin
        clk_sys = 1'h0;
        forever #2 clk_sys = ~clk_sys;
    end

    // A hang counts as a mismatch and closes the run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        rst        = 1'h1;
        reg_addr   = 4'h0;
        reg_wdata  = 16'h0000;
        reg_wr     = 1'h0;
        reg_rd     = 1'h0;
        periph_req = 20'hFFFFF;
        shadow     = RST_WORDS;
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        // Levels and requests straight after the first reset
        @(posedge clk_sys);
        #1;
        check_outs();
        // Ordinary cases, all sources requesting
        foreach (rows[i]) begin
            row_step(rows[i].a, rows[i].w, rows[i].e);
        end
        // Write then read on the very next cycle; unused bits set in the data
        @(posedge clk_sys);
        reg_wr    <= 1'h1;
        reg_addr  <= 4'h1;
        reg_wdata <= 16'hF8F8;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        cmp_word("read_after_write", 16'h7070, reg_rdata);
        @(posedge clk_sys);
        #1;
        cmp_word("rdata_idle", 16'h0000, reg_rdata);
        shadow[1] = 16'h7070;
        // Single request, seen one cycle later
        @(posedge clk_sys);
        periph_req <= 20'h00004;
        @(posedge clk_sys);
        #1;
        check_outs();
        // Disabling the requesting source blocks it
        row_step(4'h1, 16'h0000, 16'h0000);
        // Reset in mid-run restores level four everywhere
        @(posedge clk_sys);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        shadow = RST_WORDS;
        for (int k = 0; k < 6; k++) begin
            rd_reg(4'(k));
            cmp_word("reset_word", RST_WORDS[k], rd_val);
        end
        check_outs();
        tally_and_finish();
    end
endmodule
